/* File: verilog/bmpm_regs.svh */
`ifndef BMPM_REGS_SVH
`define BMPM_REGS_SVH

// register byte offsets
`define BMPM_OFS_CMD   8'h00
`define BMPM_OFS_CFG   8'h04
`define BMPM_OFS_RELAX 8'h08
`define BMPM_OFS_WAKE  8'h0C
`define BMPM_OFS_TEMP  8'h10
`define BMPM_OFS_STAT  8'h14

// settings width and status mode field position
`define BMPM_CFG_W     12
`define BMPM_STAT_MODE 4

// one-time-programmable defaults, restored on every power-up
`define BMPM_CFG_RST   12'hFD1
`define BMPM_RELAX_RST 16'h000A
`define BMPM_WAKE_RST  16'h0064
`define BMPM_TEMP_RST  16'h0FA0

// timing
`define BMPM_CLK_NS      50
`define BMPM_SAMPLE_US   2440
`define BMPM_HOLD_S      10
`define BMPM_START_US    8000
`define BMPM_PWRUP_US    10000
`define BMPM_OSC_WAKE_CYC 64

`endif

/* File: verilog/bmpm_pkg.sv */
package bmpm_pkg;

  typedef enum logic [2:0] {
    BMPM_POWERUP, BMPM_NORMAL, BMPM_SLEEP, BMPM_DEEP,
    BMPM_STARTUP, BMPM_SOFTSD, BMPM_SHUT, BMPM_CFGUPD
  } bmpm_mode_t;

  typedef enum logic [7:0] {
    BMPM_CMD_SLEEP_ALLOW  = 8'h01,
    BMPM_CMD_SLEEP_FORBID = 8'h02,
    BMPM_CMD_SLEEP_EXIT   = 8'h03,
    BMPM_CMD_HOLD_CLEAR   = 8'h04,
    BMPM_CMD_DEEP_ENTER   = 8'h10,
    BMPM_CMD_DEEP_EXIT    = 8'h11,
    BMPM_CMD_SHUTDOWN     = 8'h20,
    BMPM_CMD_SD_ABORT     = 8'h21,
    BMPM_CMD_CFG_ENTER    = 8'h30,
    BMPM_CMD_CFG_EXIT     = 8'h31
  } bmpm_cmd_t;

  typedef struct packed {
    logic [4:0] populated;
    logic       aux_en;
    logic       osc_stop;
    logic       hwot_sd;
    logic       temp_sd;
    logic       cell_sd;
    logic       stack_sd;
    logic       sleep_en;
  } bmpm_cfg_t;

  typedef struct packed {
    logic [15:0] cur_mag;
    logic        cur_valid;
    logic [15:0] int_temp;
    logic        int_temp_valid;
    logic        prot_fault;
    logic        stack_low;
    logic [4:0]  cell_low;
    logic        loop_done;
  } bmpm_meas_t;

  typedef struct packed {
    logic charge_fet_drive;
    logic discharge_fet_drive;
    logic meas_en;
    logic meas_slow;
    logic prot_en;
    logic comp_prot_en;
    logic core_reg_on;
    logic aux_regulator_output;
    logic slow_oscillator;
    logic stretch;
    logic otp_load;
    logic full_reset;
    logic cur_sample;
    logic sleep_flag;
  } bmpm_out_t;

  typedef struct packed {
    bmpm_mode_t  mode;
    logic [31:0] cnt;
    logic [31:0] hold;
    logic [31:0] tick;
    logic [7:0]  wk;
    logic        sleep_allow;
    bmpm_cfg_t   cfg;
    logic [15:0] relax;
    logic [15:0] wake;
    logic [15:0] temp_th;
    logic [31:0] rdata;
    bmpm_out_t   o;
  } bmpm_state_t;

endpackage : bmpm_pkg

/* File: verilog/bmpm_sync.sv */
`timescale 1ns/100ps

module bmpm_sync
#(
  parameter int W = 5
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
    logic [W-1:0] prev;
  } bmpm_sync_st_t;

  bmpm_sync_st_t s_reg;
  bmpm_sync_st_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.meta = d;
    s_next.q    = s_reg.meta;
    s_next.prev = s_reg.q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // edges are taken only after the second flop
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign lvl[i]  = s_reg.q[i];
      assign rise[i] = s_reg.q[i] & ~s_reg.prev[i];
      assign fall[i] = ~s_reg.q[i] & s_reg.prev[i];
    end
  endgenerate

endmodule : bmpm_sync

/* File: verilog/bmpm_power_fsm.sv */
`timescale 1ns/100ps
`include "bmpm_regs.svh"

module bmpm_power_fsm
#(
  parameter int unsigned SAMPLE_CYC = `BMPM_SAMPLE_US * 1000 / `BMPM_CLK_NS,
  parameter int unsigned HOLD_CYC   = `BMPM_HOLD_S * (1000000000 / `BMPM_CLK_NS),
  parameter int unsigned START_CYC  = `BMPM_START_US * 1000 / `BMPM_CLK_NS,
  parameter int unsigned PWRUP_CYC  = `BMPM_PWRUP_US * 1000 / `BMPM_CLK_NS,
  parameter int unsigned OSC_CYC    = `BMPM_OSC_WAKE_CYC
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  input  wire bmpm_pkg::bmpm_meas_t meas,
  input  wire logic                 thermistor_pin,
  input  wire logic                 bottom_cell_pin,
  input  wire logic                 supply_sense_low,
  input  wire logic                 hw_overtemp,
  input  wire logic                 scl_i,
  output logic                      scl_o,
  output logic                      scl_oe,
  output bmpm_pkg::bmpm_out_t       ctl
);

  localparam bmpm_pkg::bmpm_cfg_t CFG_RST = `BMPM_CFG_RST;

  localparam bmpm_pkg::bmpm_out_t OUT_RST = '{
    core_reg_on: 1'b1, slow_oscillator: 1'b1, otp_load: 1'b1, default: 1'b0};

  localparam bmpm_pkg::bmpm_state_t ST_RST = '{
    mode:        bmpm_pkg::BMPM_POWERUP,
    cnt:         32'(PWRUP_CYC),
    hold:        32'h0,
    tick:        32'h0,
    wk:          8'h0,
    sleep_allow: CFG_RST.sleep_en,
    cfg:         CFG_RST,
    relax:       `BMPM_RELAX_RST,
    wake:        `BMPM_WAKE_RST,
    temp_th:     `BMPM_TEMP_RST,
    rdata:       32'h0,
    o:           OUT_RST};

  bmpm_pkg::bmpm_state_t st_reg;
  bmpm_pkg::bmpm_state_t st_next;

  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  bmpm_sync #(
    .W (5)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({scl_i, hw_overtemp, supply_sense_low, bottom_cell_pin, thermistor_pin}),
    .lvl   (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  logic       wake_lvl;
  logic       wake_edge;
  logic       sup_low;
  logic       hwot;
  logic       scl_fall;
  logic       cmd_ok;
  logic [7:0] cmd;
  logic       sd_req;
  logic       cell_low_any;
  logic       relax_now;

  assign wake_lvl     = pin_lvl[0] | pin_lvl[1];
  assign wake_edge    = pin_rise[0] | pin_rise[1];
  assign sup_low      = pin_lvl[2];
  assign hwot         = pin_lvl[3];
  assign scl_fall     = pin_fall[4];
  assign cmd          = wdata[7:0];
  // serial traffic is ignored while powered down
  assign cmd_ok       = wr && addr == `BMPM_OFS_CMD && st_reg.mode != bmpm_pkg::BMPM_SHUT;
  assign cell_low_any = |(meas.cell_low & st_reg.cfg.populated);
  assign relax_now    = meas.cur_valid && meas.cur_mag < st_reg.relax;

  assign sd_req = (cmd_ok && cmd == bmpm_pkg::BMPM_CMD_SHUTDOWN)
                || (st_reg.cfg.stack_sd && meas.stack_low)
                || (st_reg.cfg.cell_sd && cell_low_any)
                || (st_reg.cfg.temp_sd && meas.int_temp_valid
                    && meas.int_temp > st_reg.temp_th)
                || (st_reg.cfg.hwot_sd && hwot);

  always_comb
  begin
    st_next              = st_reg;
    st_next.o.otp_load   = 1'b0;
    st_next.o.full_reset = 1'b0;
    st_next.o.cur_sample = 1'b0;
    st_next.rdata        = 32'h0;
    if (st_reg.hold != 32'h0)
      st_next.hold = st_reg.hold - 32'h1;
    if (st_reg.cnt != 32'h0)
      st_next.cnt = st_reg.cnt - 32'h1;

    if (cmd_ok)
    begin
      case (cmd)
        bmpm_pkg::BMPM_CMD_SLEEP_ALLOW:  st_next.sleep_allow = 1'b1;
        bmpm_pkg::BMPM_CMD_SLEEP_FORBID: st_next.sleep_allow = 1'b0;
        bmpm_pkg::BMPM_CMD_HOLD_CLEAR:   st_next.hold = 32'h0;
        default:                         st_next.hold = st_next.hold;
      endcase
    end

    case (st_reg.mode)
      bmpm_pkg::BMPM_NORMAL, bmpm_pkg::BMPM_SLEEP:
      begin
        if (sd_req)
          // a present wake condition parks in soft shutdown
          st_next.mode = wake_lvl ? bmpm_pkg::BMPM_SOFTSD : bmpm_pkg::BMPM_SHUT;
        else if (cmd_ok && cmd == bmpm_pkg::BMPM_CMD_DEEP_ENTER)
          st_next.mode = bmpm_pkg::BMPM_DEEP;
        else if (st_reg.mode == bmpm_pkg::BMPM_NORMAL)
        begin
          if (cmd_ok && cmd == bmpm_pkg::BMPM_CMD_CFG_ENTER)
            st_next.mode = bmpm_pkg::BMPM_CFGUPD;
          else if (st_reg.sleep_allow && st_reg.hold == 32'h0 && relax_now
                   && !meas.prot_fault)
          begin
            st_next.mode = bmpm_pkg::BMPM_SLEEP;
            st_next.tick = 32'(SAMPLE_CYC);
          end
        end
        else if (meas.prot_fault || (cmd_ok && cmd == bmpm_pkg::BMPM_CMD_SLEEP_EXIT)
                 || (meas.cur_valid && meas.cur_mag > st_reg.wake))
        begin
          st_next.mode = bmpm_pkg::BMPM_NORMAL;
          st_next.hold = 32'(HOLD_CYC);
        end
        else if (st_reg.tick == 32'h0)
        begin
          st_next.o.cur_sample = 1'b1;
          st_next.tick         = 32'(SAMPLE_CYC);
        end
        else
          st_next.tick = st_reg.tick - 32'h1;
      end
      bmpm_pkg::BMPM_DEEP:
      begin
        if (sup_low)
          st_next.mode = bmpm_pkg::BMPM_SHUT;
        else if ((cmd_ok && cmd == bmpm_pkg::BMPM_CMD_DEEP_EXIT) || wake_edge)
        begin
          st_next.mode = bmpm_pkg::BMPM_STARTUP;
          st_next.cnt  = 32'(START_CYC);
        end
      end
      bmpm_pkg::BMPM_STARTUP:
      begin
        // fixed settle time, then one full measurement loop
        if (st_reg.cnt == 32'h0 && meas.loop_done)
          st_next.mode = bmpm_pkg::BMPM_NORMAL;
      end
      bmpm_pkg::BMPM_SOFTSD:
      begin
        if (cmd_ok && cmd == bmpm_pkg::BMPM_CMD_SD_ABORT)
        begin
          st_next.mode         = bmpm_pkg::BMPM_POWERUP;
          st_next.o.full_reset = 1'b1;
        end
        else if (!wake_lvl)
          st_next.mode = bmpm_pkg::BMPM_SHUT;
      end
      bmpm_pkg::BMPM_SHUT:
      begin
        if (wake_lvl)
          st_next.mode = bmpm_pkg::BMPM_POWERUP;
      end
      bmpm_pkg::BMPM_POWERUP:
      begin
        if (st_reg.cnt == 32'h0 && meas.loop_done)
          st_next.mode = bmpm_pkg::BMPM_NORMAL;
      end
      bmpm_pkg::BMPM_CFGUPD:
      begin
        if (cmd_ok && cmd == bmpm_pkg::BMPM_CMD_CFG_EXIT)
        begin
          st_next.mode        = bmpm_pkg::BMPM_NORMAL;
          st_next.sleep_allow = st_reg.cfg.sleep_en;
        end
      end
      default:
        st_next.mode = bmpm_pkg::BMPM_POWERUP;
    endcase

    // every power-up reloads the stored defaults
    if (st_next.mode == bmpm_pkg::BMPM_POWERUP && st_reg.mode != bmpm_pkg::BMPM_POWERUP)
    begin
      st_next.cnt         = 32'(PWRUP_CYC);
      st_next.cfg         = CFG_RST;
      st_next.relax       = `BMPM_RELAX_RST;
      st_next.wake        = `BMPM_WAKE_RST;
      st_next.temp_th     = `BMPM_TEMP_RST;
      st_next.sleep_allow = CFG_RST.sleep_en;
      st_next.hold        = 32'h0;
      st_next.o.otp_load  = 1'b1;
    end

    // register writes; a write in any cycle that ends in power-up, entry cycle included, is lost
    if (wr && st_reg.mode != bmpm_pkg::BMPM_SHUT && st_next.mode != bmpm_pkg::BMPM_POWERUP)
    begin
      case (addr)
        // stored settings change only inside settings edit
        `BMPM_OFS_CFG:
          if (st_reg.mode == bmpm_pkg::BMPM_CFGUPD)
            st_next.cfg = wdata[`BMPM_CFG_W-1:0];
        `BMPM_OFS_RELAX: st_next.relax   = wdata[15:0];
        `BMPM_OFS_WAKE:  st_next.wake    = wdata[15:0];
        `BMPM_OFS_TEMP:  st_next.temp_th = wdata[15:0];
        default:         st_next.relax   = st_next.relax;
      endcase
    end

    // a read in the cycle that enters shutdown also answers zero
    if (rd && st_reg.mode != bmpm_pkg::BMPM_SHUT && st_next.mode != bmpm_pkg::BMPM_SHUT)
    begin
      case (addr)
        `BMPM_OFS_CFG:   st_next.rdata = {20'h0, st_reg.cfg};
        `BMPM_OFS_RELAX: st_next.rdata = {16'h0, st_reg.relax};
        `BMPM_OFS_WAKE:  st_next.rdata = {16'h0, st_reg.wake};
        `BMPM_OFS_TEMP:  st_next.rdata = {16'h0, st_reg.temp_th};
        `BMPM_OFS_STAT:
          st_next.rdata = {25'h0, st_reg.mode, 1'b0, st_reg.hold != 32'h0,
                           st_reg.sleep_allow, st_reg.mode == bmpm_pkg::BMPM_SLEEP};
        default:         st_next.rdata = 32'h0;
      endcase
    end

    // oscillator may stop in deep standby; serial clock activity restarts it
    if (st_next.mode == bmpm_pkg::BMPM_SHUT)
    begin
      st_next.o.slow_oscillator = 1'b0;
      st_next.o.stretch         = 1'b0;
    end
    else if (st_next.mode != bmpm_pkg::BMPM_DEEP)
    begin
      st_next.o.slow_oscillator = 1'b1;
      st_next.o.stretch         = 1'b0;
    end
    else if (st_reg.mode != bmpm_pkg::BMPM_DEEP)
      st_next.o.slow_oscillator = !st_reg.cfg.osc_stop;
    else if (st_reg.o.stretch)
    begin
      if (st_reg.wk == 8'h0)
      begin
        st_next.o.stretch         = 1'b0;
        st_next.o.slow_oscillator = 1'b1;
      end
      else
        st_next.wk = st_reg.wk - 8'h1;
    end
    else if (!st_reg.o.slow_oscillator && scl_fall)
    begin
      st_next.o.stretch = 1'b1;
      st_next.wk        = 8'(OSC_CYC);
    end

    case (st_next.mode)
      bmpm_pkg::BMPM_NORMAL, bmpm_pkg::BMPM_SLEEP:
      begin
        st_next.o.charge_fet_drive    = !meas.prot_fault;
        st_next.o.discharge_fet_drive = !meas.prot_fault;
        st_next.o.meas_en             = 1'b1;
        st_next.o.prot_en             = 1'b1;
        st_next.o.comp_prot_en        = 1'b1;
      end
      bmpm_pkg::BMPM_STARTUP, bmpm_pkg::BMPM_POWERUP:
      begin
        st_next.o.charge_fet_drive    = 1'b0;
        st_next.o.discharge_fet_drive = 1'b0;
        st_next.o.meas_en             = 1'b1;
        st_next.o.prot_en             = 1'b1;
        st_next.o.comp_prot_en        = 1'b1;
      end
      default:
      begin
        st_next.o.charge_fet_drive    = 1'b0;
        st_next.o.discharge_fet_drive = 1'b0;
        st_next.o.meas_en             = 1'b0;
        st_next.o.prot_en             = 1'b0;
        st_next.o.comp_prot_en        = 1'b0;
      end
    endcase
    st_next.o.meas_slow  = st_next.mode == bmpm_pkg::BMPM_SLEEP;
    st_next.o.sleep_flag = st_next.mode == bmpm_pkg::BMPM_SLEEP;
    st_next.o.core_reg_on = st_next.mode != bmpm_pkg::BMPM_SHUT;
    if (st_next.mode == bmpm_pkg::BMPM_SHUT || st_next.mode == bmpm_pkg::BMPM_POWERUP)
      st_next.o.aux_regulator_output = 1'b0;
    else if (st_next.mode != bmpm_pkg::BMPM_DEEP)
      st_next.o.aux_regulator_output = st_next.cfg.aux_en;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  assign rdata  = st_reg.rdata;
  assign ctl    = st_reg.o;
  assign scl_o  = 1'b0;
  assign scl_oe = st_reg.o.stretch;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_sleep_flag;
    st_reg.o.sleep_flag == (st_reg.mode == bmpm_pkg::BMPM_SLEEP);
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag wrong");

  property p_relax_entry;
    st_reg.mode == bmpm_pkg::BMPM_NORMAL && st_reg.sleep_allow && st_reg.hold == 32'h0
      && relax_now && !meas.prot_fault && !sd_req && !cmd_ok
      |=> st_reg.mode == bmpm_pkg::BMPM_SLEEP && st_reg.o.comp_prot_en;
  endproperty
  a_relax_entry: assert property (p_relax_entry) else $error("no sleep entry");

  property p_sleep_fault;
    st_reg.mode == bmpm_pkg::BMPM_SLEEP && meas.prot_fault && !sd_req && !cmd_ok
      |=> st_reg.mode == bmpm_pkg::BMPM_NORMAL && st_reg.hold == 32'(HOLD_CYC);
  endproperty
  a_sleep_fault: assert property (p_sleep_fault) else $error("fault kept sleep");

  property p_sample;
    st_reg.o.cur_sample |-> $past(st_reg.mode) == bmpm_pkg::BMPM_SLEEP
      && $past(st_reg.tick) == 32'h0 && st_reg.tick == 32'(SAMPLE_CYC);
  endproperty
  a_sample: assert property (p_sample) else $error("bad sample pulse");

  property p_deep_off;
    st_reg.mode == bmpm_pkg::BMPM_DEEP ##1 st_reg.mode == bmpm_pkg::BMPM_DEEP
      |-> !st_reg.o.discharge_fet_drive && !st_reg.o.meas_en && !st_reg.o.prot_en
      && $stable(st_reg.o.aux_regulator_output);
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep not quiet");

  property p_deep_wake;
    st_reg.mode == bmpm_pkg::BMPM_DEEP && !sup_low && wake_edge
      |=> st_reg.mode == bmpm_pkg::BMPM_STARTUP ##1 !st_reg.o.charge_fet_drive;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake missed");

  property p_deep_supply;
    st_reg.mode == bmpm_pkg::BMPM_DEEP && sup_low |=> st_reg.mode == bmpm_pkg::BMPM_SHUT;
  endproperty
  a_deep_supply: assert property (p_deep_supply) else $error("low supply ignored");

  property p_shut_off;
    st_reg.mode == bmpm_pkg::BMPM_SHUT |-> !st_reg.o.core_reg_on
      && !st_reg.o.aux_regulator_output && !st_reg.o.charge_fet_drive && rdata == 32'h0;
  endproperty
  a_shut_off: assert property (p_shut_off) else $error("shutdown not off");

  property p_soft_hold;
    st_reg.mode == bmpm_pkg::BMPM_SOFTSD && wake_lvl && !cmd_ok
      |=> st_reg.mode == bmpm_pkg::BMPM_SOFTSD && !st_reg.o.meas_en;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft shutdown left");

  property p_abort;
    st_reg.mode == bmpm_pkg::BMPM_SOFTSD && cmd_ok && cmd == bmpm_pkg::BMPM_CMD_SD_ABORT
      |=> st_reg.o.full_reset && st_reg.o.otp_load && st_reg.cfg == CFG_RST;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without reset");

  property p_stretch;
    st_reg.o.stretch |-> !st_reg.o.slow_oscillator && scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch with clock");

  c_sleep:  cover property (st_reg.mode == bmpm_pkg::BMPM_SLEEP ##1
                            st_reg.mode == bmpm_pkg::BMPM_NORMAL);
  c_deep:   cover property (st_reg.mode == bmpm_pkg::BMPM_STARTUP ##1
                            st_reg.mode == bmpm_pkg::BMPM_NORMAL);
  c_soft:   cover property (st_reg.mode == bmpm_pkg::BMPM_SOFTSD ##1
                            st_reg.mode == bmpm_pkg::BMPM_SHUT);
  c_cfgupd: cover property (st_reg.mode == bmpm_pkg::BMPM_CFGUPD ##1
                            st_reg.mode == bmpm_pkg::BMPM_NORMAL);

endmodule : bmpm_power_fsm

/* File: bench/bmpm_host_link.sv */
`timescale 1ns/100ps

// far-side master: one frame of nine serial clock pulses per rising start;
// the line idles high because scl_drv is held high, and the clock stands still between frames
module bmpm_host_link
(
  input  wire logic start,
  input  wire logic scl_line,
  output logic      scl_drv
);
  int i;

  initial
  begin
    scl_drv = 1'b1;
    forever
    begin
      @(posedge start);
      // odd offset keeps the link clock unrelated in phase to clk
      #37;
      for (i = 0; i < 9; i++)
      begin
        scl_drv = 1'b0;
        #200;
        scl_drv = 1'b1;
        // a line still low after release means the device stretches; wait it out
        wait (scl_line === 1'b1);
        #200;
      end
    end
  end
endmodule : bmpm_host_link

/* File: bench/battery_monitor_power_mode_fsm_test.sv */
`timescale 1ns/100ps
`include "bmpm_regs.svh"

module battery_monitor_power_mode_fsm_test;
  logic                clk;
  logic                rst_n;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic                wr;
  logic                rd;
  logic [31:0]         rdata;
  bmpm_pkg::bmpm_meas_t meas;
  logic                thermistor_pin;
  logic                bottom_cell_pin;
  logic                supply_sense_low;
  logic                hw_overtemp;
  logic                scl_o;
  logic                scl_oe;
  logic                scl_drv;
  logic                scl_line;
  logic                link_start;
  bmpm_pkg::bmpm_out_t ctl;
  int                  err_count;
  int                  n_checks;

  assign scl_line = scl_oe ? scl_o : scl_drv;

  bmpm_power_fsm #(.SAMPLE_CYC(20), .HOLD_CYC(50), .START_CYC(10), .PWRUP_CYC(10),
    .OSC_CYC(4)) bmpm_power_fsm_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .thermistor_pin(thermistor_pin),
    .bottom_cell_pin(bottom_cell_pin), .supply_sense_low(supply_sense_low),
    .hw_overtemp(hw_overtemp), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .ctl(ctl));

  bmpm_host_link bmpm_host_link_i (.start(link_start), .scl_line(scl_line), .scl_drv(scl_drv));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic cmd(input logic [7:0] c);
    wr_reg(`BMPM_OFS_CMD, {24'h000000, c});
  endtask : cmd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask : rd_chk

  task automatic wait_mode(input logic [2:0] m);
    logic [31:0] d;
    int          i;
    d = 32'h00000000;
    for (i = 0; i < 400 && d[6:4] !== m; i++)
      rd_reg(`BMPM_OFS_STAT, d);
    check(32'(d[6:4]), 32'(m));
  endtask : wait_mode

  task automatic t_reset();
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    check(32'({ctl.charge_fet_drive, ctl.discharge_fet_drive}), 32'h3);
    wr_reg(`BMPM_OFS_CFG, 32'h00000000);
    rd_chk(`BMPM_OFS_CFG, 32'(`BMPM_CFG_RST));
    rd_chk(`BMPM_OFS_RELAX, 32'(`BMPM_RELAX_RST));
    rd_chk(`BMPM_OFS_WAKE, 32'(`BMPM_WAKE_RST));
    rd_chk(`BMPM_OFS_TEMP, 32'(`BMPM_TEMP_RST));
    rd_chk(8'h20, 32'h00000000);
    wr_reg(`BMPM_OFS_RELAX, 32'h00000020);
    wr_reg(`BMPM_OFS_WAKE, 32'h00000080);
    wr_reg(`BMPM_OFS_TEMP, 32'h00001234);
    rd_chk(`BMPM_OFS_RELAX, 32'h00000020);
    rd_chk(`BMPM_OFS_WAKE, 32'h00000080);
    rd_chk(`BMPM_OFS_TEMP, 32'h00001234);
  endtask : t_reset

  task automatic t_sleep();
    logic [31:0] d;
    int          i;
    @(posedge clk);
    meas.cur_mag <= 16'h0005;
    wait_mode(bmpm_pkg::BMPM_SLEEP);
    check(32'({ctl.sleep_flag, ctl.meas_slow, ctl.comp_prot_en}), 32'h7);
    for (i = 0; i < 30 && ctl.cur_sample !== 1'b1; i++)
      @(negedge clk);
    check(32'(ctl.cur_sample), 32'h1);
    @(posedge clk);
    meas.prot_fault <= 1'b1;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    @(posedge clk);
    meas.prot_fault <= 1'b0;
    repeat (10) @(negedge clk);
    rd_reg(`BMPM_OFS_STAT, d);
    check(32'(d[6:4]), 32'(bmpm_pkg::BMPM_NORMAL));
    check(32'(d[2]), 32'h1);
    cmd(bmpm_pkg::BMPM_CMD_HOLD_CLEAR);
    wait_mode(bmpm_pkg::BMPM_SLEEP);
    @(posedge clk);
    meas.cur_mag <= 16'h0100;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    cmd(bmpm_pkg::BMPM_CMD_HOLD_CLEAR);
    cmd(bmpm_pkg::BMPM_CMD_SLEEP_FORBID);
    meas.cur_mag <= 16'h0005;
    repeat (10) @(negedge clk);
    rd_chk(`BMPM_OFS_STAT, 32'h00000010);
    cmd(bmpm_pkg::BMPM_CMD_SLEEP_ALLOW);
    wait_mode(bmpm_pkg::BMPM_SLEEP);
    cmd(bmpm_pkg::BMPM_CMD_SLEEP_EXIT);
    meas.cur_mag <= 16'h0100;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
  endtask : t_sleep

  task automatic t_deep();
    cmd(bmpm_pkg::BMPM_CMD_DEEP_ENTER);
    wait_mode(bmpm_pkg::BMPM_DEEP);
    check(32'({ctl.charge_fet_drive, ctl.discharge_fet_drive, ctl.meas_en, ctl.prot_en}),
      32'h0);
    check(32'(ctl.aux_regulator_output), 32'h1);
    @(posedge clk);
    thermistor_pin <= 1'b1;
    wait_mode(bmpm_pkg::BMPM_STARTUP);
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    @(posedge clk);
    thermistor_pin <= 1'b0;
    cmd(bmpm_pkg::BMPM_CMD_DEEP_ENTER);
    supply_sense_low <= 1'b1;
    repeat (10) @(negedge clk);
    check(32'({ctl.core_reg_on, ctl.aux_regulator_output, ctl.charge_fet_drive}), 32'h0);
    rd_chk(`BMPM_OFS_STAT, 32'h00000000);
    @(posedge clk);
    supply_sense_low <= 1'b0;
    bottom_cell_pin  <= 1'b1;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    // the power-up drops the thresholds written earlier
    rd_chk(`BMPM_OFS_RELAX, 32'(`BMPM_RELAX_RST));
    @(posedge clk);
    bottom_cell_pin <= 1'b0;
  endtask : t_deep

  task automatic t_hwot();
    hw_overtemp <= 1'b1;
    repeat (10) @(negedge clk);
    check(32'({ctl.core_reg_on, ctl.meas_en}), 32'h0);
    @(posedge clk);
    hw_overtemp    <= 1'b0;
    thermistor_pin <= 1'b1;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    @(posedge clk);
    thermistor_pin <= 1'b0;
  endtask : t_hwot

  task automatic t_cfg_osc();
    int i;
    cmd(bmpm_pkg::BMPM_CMD_CFG_ENTER);
    wait_mode(bmpm_pkg::BMPM_CFGUPD);
    check(32'({ctl.meas_en, ctl.prot_en}), 32'h0);
    wr_reg(`BMPM_OFS_CFG, 32'h00000FF1);
    cmd(bmpm_pkg::BMPM_CMD_CFG_EXIT);
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    rd_chk(`BMPM_OFS_CFG, 32'h00000FF1);
    cmd(bmpm_pkg::BMPM_CMD_DEEP_ENTER);
    repeat (5) @(negedge clk);
    check(32'(ctl.slow_oscillator), 32'h0);
    link_start <= 1'b1;
    for (i = 0; i < 200 && scl_oe !== 1'b1; i++)
      @(negedge clk);
    check(32'(scl_oe), 32'h1);
    for (i = 0; i < 200 && scl_oe !== 1'b0; i++)
      @(negedge clk);
    check(32'(ctl.slow_oscillator), 32'h1);
    repeat (100) @(negedge clk);
    link_start <= 1'b0;
    cmd(bmpm_pkg::BMPM_CMD_DEEP_EXIT);
    wait_mode(bmpm_pkg::BMPM_NORMAL);
  endtask : t_cfg_osc

  task automatic t_softsd();
    @(posedge clk);
    thermistor_pin <= 1'b1;
    repeat (5) @(negedge clk);
    cmd(bmpm_pkg::BMPM_CMD_SHUTDOWN);
    wait_mode(bmpm_pkg::BMPM_SOFTSD);
    check(32'({ctl.charge_fet_drive, ctl.meas_en, ctl.prot_en}), 32'h0);
    cmd(bmpm_pkg::BMPM_CMD_SD_ABORT);
    @(negedge clk);
    check(32'({ctl.full_reset, ctl.otp_load}), 32'h3);
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    // full reset brings the stored defaults back over the edited settings
    rd_chk(`BMPM_OFS_CFG, 32'(`BMPM_CFG_RST));
    @(posedge clk);
    thermistor_pin <= 1'b0;
  endtask : t_softsd

  task automatic set_cfg(input logic [31:0] v);
    cmd(bmpm_pkg::BMPM_CMD_CFG_ENTER);
    wait_mode(bmpm_pkg::BMPM_CFGUPD);
    wr_reg(`BMPM_OFS_CFG, v);
    cmd(bmpm_pkg::BMPM_CMD_CFG_EXIT);
    wait_mode(bmpm_pkg::BMPM_NORMAL);
  endtask : set_cfg

  task automatic t_cell_sd();
    // two cells populated, cell-low shutdown on
    set_cfg(32'h00000184);
    @(posedge clk);
    meas.cell_low <= 5'b11100;
    repeat (10) @(negedge clk);
    rd_chk(`BMPM_OFS_STAT, 32'h00000010);
    @(posedge clk);
    meas.cell_low <= 5'b00001;
    repeat (10) @(negedge clk);
    check(32'(ctl.core_reg_on), 32'h0);
    @(posedge clk);
    meas.cell_low  <= 5'b00000;
    thermistor_pin <= 1'b1;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    @(posedge clk);
    thermistor_pin <= 1'b0;
  endtask : t_cell_sd

  task automatic t_temp_sd();
    set_cfg(32'h00000008);
    @(posedge clk);
    meas.int_temp       <= 16'h0FA0;
    meas.int_temp_valid <= 1'b1;
    repeat (10) @(negedge clk);
    rd_chk(`BMPM_OFS_STAT, 32'h00000010);
    @(posedge clk);
    meas.int_temp <= 16'h0FA1;
    repeat (10) @(negedge clk);
    check(32'(ctl.core_reg_on), 32'h0);
    @(posedge clk);
    meas.int_temp_valid <= 1'b0;
    bottom_cell_pin     <= 1'b1;
    wait_mode(bmpm_pkg::BMPM_NORMAL);
    @(posedge clk);
    bottom_cell_pin <= 1'b0;
  endtask : t_temp_sd

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #3000000;
    err_count++;
    results();
  end

  initial
  begin
    err_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    meas = '0;
    meas.loop_done = 1'b1;
    meas.cur_valid = 1'b1;
    meas.cur_mag = 16'h0100;
    thermistor_pin = 1'b0;
    bottom_cell_pin = 1'b0;
    supply_sense_low = 1'b0;
    hw_overtemp = 1'b0;
    link_start = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_sleep();
    t_deep();
    t_hwot();
    t_cfg_osc();
    t_softsd();
    t_cell_sd();
    t_temp_sd();
    results();
  end
endmodule : battery_monitor_power_mode_fsm_test
